// >>> dcw_cmd_slot.sv
module dcw_cmd_slot
    import dcw_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        sys_rst_in,
    input  wire dcw_ctype_e  ctype_in,
    input  wire logic        start_in,
    input  wire logic        intr_in,
    input  wire logic        clear_in,
    input  wire logic        drive_en_in,
    input  wire logic        done_in,
    input  wire logic        fail_in,
    output dcw_cstate_e      state_out,
    output logic             mon_on_out
);
    dcw_cstate_e                     state;
    dcw_cstate_e                     next_state;
    logic                            mon_on;
    logic                            next_mon_on;
    logic [$clog2(DCW_ADMIN_CYC):0]  cnt;
    logic [$clog2(DCW_ADMIN_CYC):0]  next_cnt;

    always_comb begin
        next_state  = state;
        next_mon_on = mon_on;
        next_cnt    = cnt;
        case (state)
            DCW_ST_IDLE: begin
                if (start_in) begin
                    if (ctype_in == DCW_CT_DRIVE && !drive_en_in) begin
                        next_state = DCW_ST_FAIL;
                    end else begin
                        next_state = DCW_ST_BUSY;
                        next_cnt   = '0;
                    end
                end
            end
            DCW_ST_BUSY: begin
                next_cnt = cnt + 1'b1;
                if (intr_in && ctype_in != DCW_CT_ADMIN) begin
                    next_state = DCW_ST_IDLE;
                end else if (clear_in && ctype_in != DCW_CT_ADMIN) begin
                    next_state = DCW_ST_IDLE;
                end else if (fail_in) begin
                    next_state = DCW_ST_FAIL;
                end else if (ctype_in == DCW_CT_ADMIN) begin
                    if (cnt == ($clog2(DCW_ADMIN_CYC)+1)'(DCW_ADMIN_CYC - 1)) begin
                        next_state = DCW_ST_DONE;
                    end
                end else if (done_in || ctype_in == DCW_CT_MON) begin
                    if (ctype_in == DCW_CT_MON) begin
                        next_mon_on = !mon_on;
                    end
                    next_state = DCW_ST_DONE;
                end
            end
            default: begin
                if (clear_in) begin
                    next_state = DCW_ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state  <= DCW_ST_IDLE;
            mon_on <= 1'b0;
            cnt    <= '0;
        end else begin
            state  <= next_state;
            mon_on <= next_mon_on;
            cnt    <= next_cnt;
        end
    end

    assign state_out  = state;
    assign mon_on_out = mon_on;
endmodule // dcw_cmd_slot

// >>> dcw_ctrl_model.sv
module dcw_ctrl_model
    import dcw_pkg::*;
(
    input  wire logic sys_clk_in,
    output dcw_req_s  param_req_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial param_req_out = '0;

    // start 11b, interrupt 01, clear 00; one request per cycle
    task automatic send(input logic [2:0] idx, input logic [1:0] value);
        param_req_out = '{1'b1, idx, value};
        @(negedge sys_clk_in);
    endtask

    // released lines show the inverse so stale values never look valid
    task automatic rel();
        param_req_out = '{1'b0, ~param_req_out.idx, ~param_req_out.value};
    endtask
endmodule // dcw_ctrl_model

// >>> dcw_diag_checker.sv
module dcw_diag_checker
    import dcw_pkg::*;
#(
    parameter int unsigned NUM_CMDS  = DCW_NUM_CMDS,
    parameter int unsigned WARN_W    = DCW_WARN_W,
    parameter logic [15:0] CMD_TYPES = 16'h0094
)
(
    input  wire logic                  sys_clk_in,
    input  wire logic                  sys_rst_in,
    input  wire dcw_req_s              param_req_in,
    input  wire logic                  panel_start_in,
    input  wire logic [DCW_CMD_W-1:0]  panel_idx_in,
    input  wire logic                  drive_en_in,
    input  wire logic [WARN_W-1:0]     pre_err_in,
    input  wire logic [WARN_W-1:0]     react_cls_in,
    input  wire logic [WARN_W-1:0]     mains_in,
    input  wire logic [WARN_W-1:0]     limit_in,
    input  wire logic                  power_off_cfg_in,
    input  wire logic [2*NUM_CMDS-1:0] cmd_status_out,
    input  wire logic                  motion_own_out,
    input  wire dcw_diag_s             diag_num_out,
    input  wire dcw_diag_s             diag_disp_out,
    input  wire logic                  cmd_err_out,
    input  wire logic [WARN_W-1:0]     warn_out,
    input  wire logic                  drive_react_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // helpers: cmd 0 is drive, cmd 3 admin in this build
    // ------------------------------------------------------------
    logic                clr_any, clr0, any_fail, drv_busy, exp_react;
    logic [1:0]          st0, st3;
    logic [2:0]          stab, next_stab;
    logic [4*WARN_W:0]   win, win_q;
    logic [WARN_W-1:0]   act;

    always_comb begin
        clr_any   = param_req_in.valid && param_req_in.value == DCW_REQ_CLEAR;
        clr0      = clr_any && param_req_in.idx == 3'h0;
        st0       = cmd_status_out[1:0];
        st3       = cmd_status_out[7:6];
        any_fail  = 1'b0;
        drv_busy  = 1'b0;
        for (int i = 0; i < NUM_CMDS; i++) begin
            any_fail = any_fail | (cmd_status_out[2*i +: 2] == DCW_ST_FAIL);
            if (CMD_TYPES[2*i +: 2] == DCW_CT_DRIVE) begin
                drv_busy = drv_busy | (cmd_status_out[2*i +: 2] == DCW_ST_BUSY);
            end
        end
        act       = pre_err_in | limit_in;
        win       = {power_off_cfg_in, pre_err_in, react_cls_in, mains_in, limit_in};
        next_stab = (win != win_q) ? 3'h0 : ((stab == 3'h7) ? stab : stab + 3'h1);
        exp_react = |(act & ((mains_in & {WARN_W{power_off_cfg_in}}) | (~mains_in & react_cls_in)));
    end

    // stability count avoids guessing the exact warning pipeline depth
    always_ff @(posedge sys_clk_in) begin
        win_q <= win;
        stab  <= sys_rst_in ? 3'h0 : next_stab;
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    a_drive_needs_en: assert property (
        param_req_in.valid && param_req_in.value == DCW_REQ_START && param_req_in.idx == 3'h0
        && !drive_en_in && st0 == DCW_ST_IDLE |-> ##[1:3] st0 == DCW_ST_FAIL) else $error("drive start without enable");
    a_pend_until_clr: assert property (
        st0 != DCW_ST_DONE && st0 != DCW_ST_FAIL && ($past(st0) == DCW_ST_DONE || $past(st0) == DCW_ST_FAIL)
        |-> $past(clr0) || $past(clr0, 2) || $past(clr0, 3)) else $error("result dropped without clear");
    a_err_needs_clr: assert property (
        $fell(cmd_err_out) |-> $past(clr_any) || $past(clr_any, 2) || $past(clr_any, 3)) else $error("error lost");
    a_admin_runs: assert property (
        $past(st3) == DCW_ST_BUSY |-> st3 == DCW_ST_BUSY || st3 == DCW_ST_DONE) else $error("admin cut short");
    a_panel_refuse: assert property (
        panel_start_in && panel_idx_in == 3'h3 && !param_req_in.valid && st3 == DCW_ST_IDLE
        |=> (st3 == DCW_ST_IDLE)[*3]) else $error("panel start not refused");
    a_warn_follows: assert property (
        stab == 3'h7 && win == win_q |-> warn_out == act) else $error("warning mismatch");
    a_react_class: assert property (
        stab == 3'h7 && win == win_q |-> drive_react_out == exp_react) else $error("reaction mismatch");
    a_motion_owner: assert property (
        motion_own_out |-> drv_busy || $past(drv_busy)) else $error("motion without drive cmd");
    a_err_diag: assert property (
        any_fail [*3] |-> diag_num_out.letter == DCW_LTR_CMD && cmd_err_out) else $error("error not shown");
    a_disp_letter: assert property (
        diag_disp_out.letter == diag_num_out.letter) else $error("display letter differs");

    c_admin_done: cover property (st3 == DCW_ST_DONE);
    c_drive_fail: cover property (st0 == DCW_ST_FAIL);
    c_reaction:   cover property (drive_react_out);
endmodule // dcw_diag_checker

// >>> dcw_diag_top.sv
// Overview of operation
// - status diagnostics show phase and mode
// - parameter starts, interrupts, clears commands
// - panel may start selected commands
// - each command has one of three types
// - drive commands need drive enable
// - drive command may move, suspend mode
// - monitor command switches monitors on/off
// - admin commands ignore interrupt, finish
// - command error code names command
// - error clear leaves command error
// - warning when condition nears error
// - E1-E7 no reaction, E8 reaction
// - external warning clear ignored
// - E2 mains warning follows power-off setting
// - E2 limit subgroup on limit exceeded
// - E8 reacts, mains follows power-off setting
// - readback code may differ from display
module dcw_diag_top
    import dcw_pkg::*;
#(
    parameter int unsigned  NUM_CMDS   = DCW_NUM_CMDS,
    parameter int unsigned  WARN_W     = DCW_WARN_W,
    parameter logic [15:0]  CMD_TYPES  = 16'h0094,
    parameter logic [NUM_CMDS-1:0] PANEL_OK = 8'h03
)
(
    input  wire logic                sys_clk_in,
    input  wire logic                sys_rst_in,
    input  wire dcw_req_s            param_req_in,
    input  wire logic                panel_start_in,
    input  wire logic [DCW_CMD_W-1:0] panel_idx_in,
    input  wire logic                err_clear_in,
    input  wire logic                warn_clear_in,
    input  wire logic                drive_en_in,
    input  wire logic [NUM_CMDS-1:0] cmd_done_in,
    input  wire logic [NUM_CMDS-1:0] cmd_fail_in,
    input  wire logic [2:0]          phase_in,
    input  wire logic [3:0]          op_mode_in,
    input  wire logic [WARN_W-1:0]   pre_err_in,
    input  wire logic [WARN_W-1:0]   react_cls_in,
    input  wire logic [WARN_W-1:0]   mains_in,
    input  wire logic [WARN_W-1:0]   limit_in,
    input  wire logic                power_off_cfg_in,
    output logic [2*NUM_CMDS-1:0]    cmd_status_out,
    output logic [NUM_CMDS-1:0]      mon_on_out,
    output logic                     motion_own_out,
    output logic                     mode_suspend_out,
    output dcw_diag_s                diag_num_out,
    output dcw_diag_s                diag_disp_out,
    output logic                     cmd_err_out,
    output logic [WARN_W-1:0]        warn_out,
    output logic                     drive_react_out
);
    // ------------------------------------------------------------
    // request decoding
    // ------------------------------------------------------------
    logic [NUM_CMDS-1:0] start_v;
    logic [NUM_CMDS-1:0] intr_v;
    logic [NUM_CMDS-1:0] clear_v;
    dcw_cstate_e         st [NUM_CMDS];
    logic [NUM_CMDS-1:0] mon_v;

    genvar g;
    generate
        for (g = 0; g < NUM_CMDS; g++) begin : g_cmd
            logic hit;
            assign hit = param_req_in.valid && param_req_in.idx == DCW_CMD_W'(g);
            assign start_v[g] = (hit && param_req_in.value == DCW_REQ_START) ||
                                (panel_start_in && PANEL_OK[g] && panel_idx_in == DCW_CMD_W'(g));
            assign intr_v[g]  = hit && param_req_in.value == DCW_REQ_INTR;
            assign clear_v[g] = hit && param_req_in.value == DCW_REQ_CLEAR;
            dcw_cmd_slot u_slot (
                .sys_clk_in  (sys_clk_in),
                .sys_rst_in  (sys_rst_in),
                .ctype_in    (dcw_ctype_e'(CMD_TYPES[2*g +: 2])),
                .start_in    (start_v[g]),
                .intr_in     (intr_v[g]),
                .clear_in    (clear_v[g]),
                .drive_en_in (drive_en_in),
                .done_in     (cmd_done_in[g]),
                .fail_in     (cmd_fail_in[g]),
                .state_out   (st[g]),
                .mon_on_out  (mon_v[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // warnings
    // ------------------------------------------------------------
    logic [WARN_W-1:0] w_act;
    logic              w_react;
    logic [WARN_W-1:0] w_isr;
    logic [WARN_W-1:0] w_isl;

    // warn_clear_in unused: warnings cannot be cleared
    dcw_warn_unit #(.WARN_W(WARN_W)) u_warn (
        .sys_clk_in       (sys_clk_in),
        .sys_rst_in       (sys_rst_in),
        .pre_err_in       (pre_err_in),
        .react_cls_in     (react_cls_in),
        .mains_in         (mains_in),
        .limit_in         (limit_in),
        .power_off_cfg_in (power_off_cfg_in),
        .active_out       (w_act),
        .react_out        (w_react),
        .is_react_out     (w_isr),
        .is_limit_out     (w_isl)
    );

    // ------------------------------------------------------------
    // diagnostic selection
    // ------------------------------------------------------------
    logic [2*NUM_CMDS-1:0] next_status;
    logic [NUM_CMDS-1:0]   next_mon;
    logic                  next_motion;
    logic                  next_err;
    dcw_diag_s             next_num;
    dcw_diag_s             next_disp;
    logic [2*NUM_CMDS-1:0] status_q;
    logic [NUM_CMDS-1:0]   mon_q;
    logic                  motion_q;
    logic                  suspend_q;
    logic                  err_q;
    dcw_diag_s             num_q;
    dcw_diag_s             disp_q;
    logic [WARN_W-1:0]     warn_q;
    logic                  react_q;

    always_comb begin
        next_motion = 1'b0;
        next_err    = 1'b0;
        next_mon    = mon_v;
        next_num    = '{letter: DCW_LTR_STATUS, cls: 4'(phase_in), num: {8'h00, op_mode_in}};
        for (int i = 0; i < NUM_CMDS; i++) begin
            next_status[2*i +: 2] = st[i];
            if (st[i] == DCW_ST_BUSY && CMD_TYPES[2*i +: 2] == DCW_CT_DRIVE) begin
                next_motion = 1'b1;
            end
        end
        // warnings rank below commands
        for (int i = WARN_W - 1; i >= 0; i--) begin
            if (w_act[i]) begin
                next_num = '{letter: DCW_LTR_WARN,
                             cls: w_isr[i] ? DCW_WCLS_REACT : DCW_WCLS_LIMIT,
                             num: {4'h0, 4'(w_isl[i]), 4'(i)}};
            end
        end
        for (int i = NUM_CMDS - 1; i >= 0; i--) begin
            if (st[i] == DCW_ST_BUSY) begin
                next_num = '{letter: DCW_LTR_CMD, cls: DCW_CMD_RUN, num: {8'h00, 4'(i)}};
            end
        end
        for (int i = NUM_CMDS - 1; i >= 0; i--) begin
            if (st[i] == DCW_ST_FAIL) begin
                next_err = 1'b1;
                next_num = '{letter: DCW_LTR_CMD, cls: DCW_CMD_ERR, num: {8'h00, 4'(i)}};
            end
        end
        next_disp = next_num;
        if (next_num.letter == DCW_LTR_STATUS && phase_in == DCW_PH_MODE) begin
            next_disp.num = '0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            status_q  <= '0;
            mon_q     <= '0;
            motion_q  <= 1'b0;
            suspend_q <= 1'b0;
            err_q     <= 1'b0;
            num_q     <= '0;
            disp_q    <= '0;
            warn_q    <= '0;
            react_q   <= 1'b0;
        end else begin
            status_q  <= next_status;
            mon_q     <= next_mon;
            motion_q  <= next_motion;
            suspend_q <= next_motion;
            err_q     <= next_err;
            num_q     <= next_num;
            disp_q    <= next_disp;
            warn_q    <= w_act;
            react_q   <= w_react;
        end
    end

    assign cmd_status_out   = status_q;
    assign mon_on_out       = mon_q;
    assign motion_own_out   = motion_q;
    assign mode_suspend_out = suspend_q;
    assign cmd_err_out      = err_q;
    assign diag_num_out     = num_q;
    assign diag_disp_out    = disp_q;
    assign warn_out         = warn_q;
    assign drive_react_out  = react_q;
endmodule // dcw_diag_top

// >>> dcw_pkg.sv
package dcw_pkg;

    // ------------------------------------------------------------
    // command parameter encoding
    // ------------------------------------------------------------
    localparam logic [1:0] DCW_REQ_CLEAR  = 2'h0;
    localparam logic [1:0] DCW_REQ_INTR   = 2'h1;
    localparam logic [1:0] DCW_REQ_START  = 2'h3;

    localparam int unsigned DCW_NUM_CMDS  = 8;
    localparam int unsigned DCW_CMD_W     = 3;
    localparam int unsigned DCW_WARN_W    = 4;

    // ------------------------------------------------------------
    // diagnostic message layout: letter, class digit, three digits
    // ------------------------------------------------------------
    localparam logic [3:0] DCW_LTR_STATUS = 4'h0;
    localparam logic [3:0] DCW_LTR_CMD    = 4'hc;
    localparam logic [3:0] DCW_LTR_WARN   = 4'he;
    localparam logic [3:0] DCW_WCLS_LIMIT = 4'h2;
    localparam logic [3:0] DCW_WCLS_REACT = 4'h8;
    localparam logic [3:0] DCW_CMD_RUN    = 4'h0;
    localparam logic [3:0] DCW_CMD_ERR    = 4'h1;

    localparam logic [2:0] DCW_PH_COMM    = 3'h0;
    localparam logic [2:0] DCW_PH_BOOT    = 3'h1;
    localparam logic [2:0] DCW_PH_READY   = 3'h2;
    localparam logic [2:0] DCW_PH_MODE    = 3'h3;

    // admin command run time in cycles
    localparam int unsigned DCW_ADMIN_CYC = 16;

    typedef enum logic [1:0] {
        DCW_CT_DRIVE = 2'b00,
        DCW_CT_MON   = 2'b01,
        DCW_CT_ADMIN = 2'b10
    } dcw_ctype_e;

    typedef enum logic [1:0] {
        DCW_ST_IDLE  = 2'b00,
        DCW_ST_BUSY  = 2'b01,
        DCW_ST_DONE  = 2'b10,
        DCW_ST_FAIL  = 2'b11
    } dcw_cstate_e;

    typedef struct packed {
        logic                 valid;
        logic [DCW_CMD_W-1:0] idx;
        logic [1:0]           value;
    } dcw_req_s;

    typedef struct packed {
        logic [3:0]  letter;
        logic [3:0]  cls;
        logic [11:0] num;
    } dcw_diag_s;

endpackage : dcw_pkg

// >>> dcw_warn_unit.sv
module dcw_warn_unit
    import dcw_pkg::*;
#(
    parameter int unsigned WARN_W = DCW_WARN_W
)
(
    input  wire logic              sys_clk_in,
    input  wire logic              sys_rst_in,
    input  wire logic [WARN_W-1:0] pre_err_in,
    input  wire logic [WARN_W-1:0] react_cls_in,
    input  wire logic [WARN_W-1:0] mains_in,
    input  wire logic [WARN_W-1:0] limit_in,
    input  wire logic              power_off_cfg_in,
    output logic      [WARN_W-1:0] active_out,
    output logic                   react_out,
    output logic      [WARN_W-1:0] is_react_out,
    output logic      [WARN_W-1:0] is_limit_out
);
    logic [WARN_W-1:0] active;
    logic [WARN_W-1:0] next_active;
    logic              react;
    logic              next_react;

    always_comb begin
        next_active = pre_err_in | limit_in;
        next_react  = 1'b0;
        for (int i = 0; i < WARN_W; i++) begin
            if (next_active[i]) begin
                if (mains_in[i]) begin
                    next_react = next_react | power_off_cfg_in;
                end else if (react_cls_in[i]) begin
                    next_react = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            active <= '0;
            react  <= 1'b0;
        end else begin
            active <= next_active;
            react  <= next_react;
        end
    end

    assign active_out   = active;
    assign react_out    = react;
    assign is_react_out = react_cls_in;
    assign is_limit_out = limit_in;
endmodule // dcw_warn_unit

// >>> drive_command_and_warning_diagnostics_tb.sv
module drive_command_and_warning_diagnostics_tb
    import dcw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] TYPES = 16'h0090;
    localparam logic [7:0]  PANEL = 8'h03;

    logic        sys_clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    dcw_req_s    req;
    logic        pnl_go, err_clr, warn_clr, drv_en, pwr_cfg, motion, susp, cerr, react;
    logic [2:0]  pnl_idx, phase;
    logic [3:0]  mode, pre, rcls, mains, lim, warn;
    logic [7:0]  done_v, fail_v, mon, exp_mon;
    logic [15:0] status;
    logic [31:0] r, rng = 32'h8e3e;
    dcw_diag_s   dnum, ddisp;
    int          miscompares, n_checks, cyc, exp_st[8];
    string       tname;

    dcw_diag_top #(.CMD_TYPES(TYPES), .PANEL_OK(PANEL)) dcw_diag_top_inst (.sys_clk_in, .sys_rst_in,
        .param_req_in(req), .panel_start_in(pnl_go), .panel_idx_in(pnl_idx), .err_clear_in(err_clr),
        .warn_clear_in(warn_clr), .drive_en_in(drv_en), .cmd_done_in(done_v), .cmd_fail_in(fail_v),
        .phase_in(phase), .op_mode_in(mode), .pre_err_in(pre), .react_cls_in(rcls), .mains_in(mains),
        .limit_in(lim), .power_off_cfg_in(pwr_cfg), .cmd_status_out(status), .mon_on_out(mon),
        .motion_own_out(motion), .mode_suspend_out(susp), .diag_num_out(dnum), .diag_disp_out(ddisp),
        .cmd_err_out(cerr), .warn_out(warn), .drive_react_out(react));
    dcw_ctrl_model dcw_ctrl_model_inst (.sys_clk_in, .param_req_out(req));

    always #4 sys_clk_in = ~sys_clk_in;

    // run needs about 350 cycles
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 4000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %0t %s: seen %h expected %h", $time, tname, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    task automatic wt(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask

    // ------------------------------------------------------------
    // reference model of one command slot
    // ------------------------------------------------------------
    function automatic int model(input int i, input logic [1:0] v);
        logic [1:0] t;
        t = TYPES[2*i +: 2];
        if (v == DCW_REQ_START && exp_st[i] == 0) begin
            if (t == DCW_CT_DRIVE && !drv_en) return 3;
            if (t != DCW_CT_MON) return 1;
            exp_mon[i] = ~exp_mon[i];
            return 2;
        end
        if (v == DCW_REQ_CLEAR && !(t == DCW_CT_ADMIN && exp_st[i] == 1)) return 0;
        return exp_st[i];
    endfunction

    task automatic op(input int i, input logic [1:0] v);
        dcw_ctrl_model_inst.send(i[2:0], v);
        dcw_ctrl_model_inst.rel();
        exp_st[i] = model(i, v);
        wt(3);
        check(status[2*i +: 2], exp_st[i]);
    endtask

    initial begin
        {pnl_go, err_clr, warn_clr, drv_en, pwr_cfg} = '0;
        {pnl_idx, mode, pre, rcls, mains, lim, done_v, fail_v, exp_mon} = '0;
        phase = DCW_PH_READY;
        wt(4);
        sys_rst_in = 1'b0;
        tname = "status";
        for (int p = 0; p < 4; p++) begin
            r = rnd();
            phase = p[2:0];
            mode = r[3:0];
            wt(3);
            check(status, 16'h0000);
            check(dnum, {DCW_LTR_STATUS, 1'b0, phase, 8'h00, mode});
            check(ddisp, {DCW_LTR_STATUS, 1'b0, phase, (phase == DCW_PH_MODE) ? 12'h000 : {8'h00, mode}});
        end
        $display("test %s done", tname);
        tname = "drive";
        phase = DCW_PH_READY;
        op(0, DCW_REQ_START);
        check(dnum, {DCW_LTR_CMD, DCW_CMD_ERR, 12'h000});
        err_clr = 1'b1;
        wt(1);
        err_clr = 1'b0;
        wt(3);
        check(cerr, 1'b1);
        op(0, DCW_REQ_CLEAR);
        check(cerr, 1'b0);
        drv_en = 1'b1;
        op(1, DCW_REQ_START);
        check({motion, susp}, 2'b11);
        check(dnum, {DCW_LTR_CMD, DCW_CMD_RUN, 12'h001});
        done_v[1] = 1'b1;
        wt(2);
        done_v[1] = 1'b0;
        exp_st[1] = 2;
        wt(10);
        check(status[3:2], exp_st[1]);
        check(motion, 1'b0);
        op(1, DCW_REQ_CLEAR);
        op(4, DCW_REQ_START);
        fail_v[4] = 1'b1;
        exp_st[4] = 3;
        wt(3);
        fail_v[4] = 1'b0;
        check(dnum, {DCW_LTR_CMD, DCW_CMD_ERR, 12'h004});
        op(4, DCW_REQ_CLEAR);
        op(0, DCW_REQ_START);
        dcw_ctrl_model_inst.send(3'h0, DCW_REQ_INTR);
        dcw_ctrl_model_inst.rel();
        wt(3);
        check(status[1:0] != DCW_ST_BUSY, 1'b1);
        op(0, DCW_REQ_CLEAR);
        $display("test %s done", tname);
        tname = "monitor";
        repeat (2) begin
            op(2, DCW_REQ_START);
            check(mon, exp_mon);
            op(2, DCW_REQ_CLEAR);
        end
        $display("test %s done", tname);
        tname = "admin";
        op(3, DCW_REQ_START);
        dcw_ctrl_model_inst.send(3'h3, DCW_REQ_INTR);
        dcw_ctrl_model_inst.send(3'h3, DCW_REQ_CLEAR);
        dcw_ctrl_model_inst.send(3'h3, DCW_REQ_START);
        dcw_ctrl_model_inst.rel();
        wt(2);
        check(status[7:6], exp_st[3]);
        wt(DCW_ADMIN_CYC);
        exp_st[3] = 2;
        check(status[7:6], exp_st[3]);
        op(3, DCW_REQ_CLEAR);
        $display("test %s done", tname);
        tname = "panel";
        for (int k = 3; k >= 0; k -= 3) begin
            pnl_idx = k[2:0];
            pnl_go = 1'b1;
            wt(1);
            pnl_go = 1'b0;
            exp_st[k] = PANEL[k] ? model(k, DCW_REQ_START) : exp_st[k];
            wt(3);
            check(status[2*k +: 2], exp_st[k]);
        end
        op(0, DCW_REQ_CLEAR);
        $display("test %s done", tname);
        tname = "warning";
        for (int k = 0; k < 24; k++) begin
            r = rnd();
            {pre, rcls, mains, lim} = r[15:0];
            {pwr_cfg, warn_clr} = r[17:16];
            wt(9);
            check(warn, pre | lim);
            check(react, |((pre | lim) & ((mains & {4{pwr_cfg}}) | (~mains & rcls))));
            check(dnum.letter, ((pre | lim) != 4'h0) ? DCW_LTR_WARN : DCW_LTR_STATUS);
        end
        $display("test %s done", tname);
        conclude();
    end
endmodule // drive_command_and_warning_diagnostics_tb

bind dcw_diag_top dcw_diag_checker #(.NUM_CMDS(NUM_CMDS), .WARN_W(WARN_W), .CMD_TYPES(CMD_TYPES))
    dcw_diag_checker_inst (.sys_clk_in, .sys_rst_in, .param_req_in, .panel_start_in, .panel_idx_in,
    .drive_en_in, .pre_err_in, .react_cls_in, .mains_in, .limit_in, .power_off_cfg_in, .cmd_status_out,
    .motion_own_out, .diag_num_out, .diag_disp_out, .cmd_err_out, .warn_out, .drive_react_out);
